// file: rtl/dco_cmd_handler.sv
// Overlay command interpreter with APB task-file registers
module dco_cmd_handler
(
  input  wire logic              i_mclk,
  input  wire logic              i_reset,
  input  wire logic              i_por,
  input  dco_pkg::dco_apb_req_t  i_apb,
  output dco_pkg::dco_apb_rsp_t  o_apb,
  output dco_pkg::dco_caps_t     o_active_caps,
  output logic                   o_frozen
);
  import dco_pkg::*;

  dco_state_t  state_q;
  logic [7:0]  feature_q;
  logic [7:0]  device_q;
  logic [7:0]  error_q;
  logic [7:0]  status_q;
  logic [7:0]  sub_q;
  logic [31:0] config_q;
  logic        frozen_q;
  logic [7:0]  word_q;
  logic [7:0]  csum_q;
  logic [31:0] rdata_q;
  logic [31:0] rd_mux;
  dco_caps_t   caps_q;
  logic        wr_en;
  logic        rd_en;
  logic        cmd_go;
  logic        abort;
  logic        last_word;
  logic [15:0] id_word;
  logic        mapped;

  ////////////////////////////////////////////////////////////////////////////
  // Identify word source

  function automatic logic [15:0] ident_word(input logic [7:0] idx);
    logic [15:0] w;
    w = 16'h0000;
    case (idx)
      8'h00:   w = ID_REVISION;
      8'h01:   w = CAP_MDMA & MDMA_MASK;
      8'h02:   w = CAP_UDMA & UDMA_MASK;
      8'h03:   w = CAP_MAX_LBA[15:0];
      8'h04:   w = CAP_MAX_LBA[31:16];
      8'h05:   w = CAP_MAX_LBA[47:32];
      8'h06:   w = CAP_MAX_LBA[63:48];
      8'h07:   w = CAP_FEAT & FEAT_MASK;
      default: w = 16'h0000;
    endcase
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // APB decode; slave answers with zero wait states

  assign wr_en  = i_apb.psel && i_apb.penable && i_apb.pwrite;
  assign rd_en  = i_apb.psel && i_apb.penable && !i_apb.pwrite;
  assign cmd_go = wr_en && (i_apb.paddr == ADDR_COMMAND) && (state_q == DCO_IDLE);
  assign last_word = (word_q == ID_LAST_WORD);
  assign id_word = last_word ? {8'h00 - csum_q - ID_SIGNATURE, ID_SIGNATURE}
                             : ident_word(word_q);

  always_comb
  begin
    case (i_apb.paddr)
      ADDR_FEATURE, ADDR_DEVICE, ADDR_COMMAND, ADDR_ERROR, ADDR_STATUS,
      ADDR_DATA, ADDR_CONFIG, ADDR_CAPS, ADDR_FLAGS: mapped = 1'b1;
      default:                                       mapped = 1'b0;
    endcase
  end

  assign o_apb.pready  = 1'b1;
  assign o_apb.pslverr = i_apb.psel && i_apb.penable && !mapped;
  assign o_apb.prdata  = rdata_q;

  // Read source selected from the address of the pending transfer
  always_comb
  begin
    case (i_apb.paddr)
      ADDR_FEATURE: rd_mux = {24'h000000, feature_q};
      ADDR_DEVICE:  rd_mux = {24'h000000, device_q};
      ADDR_ERROR:   rd_mux = {24'h000000, error_q};
      ADDR_STATUS:  rd_mux = {24'h000000, status_q};
      ADDR_DATA:    rd_mux = (state_q == DCO_XFER) ? {16'h0000, id_word} : 32'h0000_0000;
      ADDR_CONFIG:  rd_mux = config_q;
      ADDR_CAPS:    rd_mux = {caps_q.udma, caps_q.feat};
      ADDR_FLAGS:   rd_mux = {31'h0000_0000, frozen_q};
      default:      rd_mux = 32'h0000_0000;
    endcase
  end

  // Captured at the end of setup; word pointer only moves on access edges,
  // so the data port cannot slip between capture and answer
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
      rdata_q <= {24'h000000, RST_BYTE};
    else if (i_apb.psel && !i_apb.penable && !i_apb.pwrite)
      rdata_q <= rd_mux;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Task-file registers

  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
      feature_q <= RST_BYTE;
    else if (wr_en && i_apb.paddr == ADDR_FEATURE)
      feature_q <= i_apb.pwdata[7:0];
  end

  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
      device_q <= RST_BYTE;
    else if (wr_en && i_apb.paddr == ADDR_DEVICE && state_q == DCO_IDLE)
      device_q <= i_apb.pwdata[7:0];   // held untouched by command
  end

  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
      config_q <= RST_CONFIG;
    else if (wr_en && i_apb.paddr == ADDR_CONFIG)
      config_q <= i_apb.pwdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Freeze lock: only power-on clears it, hardware reset leaves it

  always_ff @(posedge i_mclk or posedge i_por)
  begin
    if (i_por)
      frozen_q <= 1'b0;
    else if (state_q == DCO_EXEC && sub_q == SUB_FREEZE && !abort)
      frozen_q <= 1'b1;
  end

  assign o_frozen = frozen_q;

  ////////////////////////////////////////////////////////////////////////////
  // Abort decision

  always_comb
  begin
    case (sub_q)
      SUB_RESTORE:  abort = !config_q[CFG_SUPPORTED] || config_q[CFG_HPA] || frozen_q;
      SUB_FREEZE,
      SUB_IDENTIFY: abort = !config_q[CFG_SUPPORTED] || frozen_q;
      SUB_SET:      abort = 1'b1;             // Data-out path absent
      default:      abort = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer

  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      state_q <= DCO_IDLE;
      sub_q   <= RST_BYTE;
    end
    else
    begin
      case (state_q)
        DCO_IDLE:
          if (cmd_go)
          begin
            sub_q   <= (i_apb.pwdata[7:0] == CMD_OVERLAY) ? feature_q : RST_BYTE;
            state_q <= DCO_EXEC;
          end
        DCO_EXEC:
          state_q <= (!abort && sub_q == SUB_IDENTIFY) ? DCO_XFER : DCO_IDLE;
        DCO_XFER:
          if (rd_en && i_apb.paddr == ADDR_DATA && last_word)
            state_q <= DCO_IDLE;
        default:
          state_q <= DCO_IDLE;
      endcase
    end
  end

  // Word pointer and running byte sum over 512 bytes
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      word_q <= 8'h00;
      csum_q <= 8'h00;
    end
    else if (state_q != DCO_XFER)
    begin
      word_q <= 8'h00;
      csum_q <= 8'h00;
    end
    else if (rd_en && i_apb.paddr == ADDR_DATA)
    begin
      word_q <= word_q + 8'h01;
      csum_q <= csum_q + id_word[7:0] + id_word[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status and error

  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      status_q <= RST_STATUS;
      error_q  <= RST_BYTE;
    end
    else
    begin
      case (state_q)
        DCO_IDLE:
          if (cmd_go)
          begin
            status_q <= 8'h00;
            status_q[ST_BSY] <= 1'b1;
            status_q[ST_DRDY] <= 1'b1;
            error_q <= RST_BYTE;
          end
        DCO_EXEC:
          begin
            status_q <= 8'h00;
            status_q[ST_DRDY] <= 1'b1;
            status_q[ST_DRQ] <= !abort && sub_q == SUB_IDENTIFY;
            status_q[ST_ERR] <= abort;
            status_q[ST_DF] <= abort && config_q[CFG_FAULT];
            error_q[ER_ABRT] <= abort;
          end
        DCO_XFER:
          if (rd_en && i_apb.paddr == ADDR_DATA && last_word)
            status_q[ST_DRQ] <= 1'b0;
        default:
          status_q <= RST_STATUS;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reported capabilities, always the factory set; restore reloads it

  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      caps_q.mdma <= CAP_MDMA;
      caps_q.udma <= CAP_UDMA;
      caps_q.feat <= CAP_FEAT;
    end
    else if (state_q == DCO_EXEC && sub_q == SUB_RESTORE && !abort)
    begin
      caps_q.mdma <= CAP_MDMA;
      caps_q.udma <= CAP_UDMA;
      caps_q.feat <= CAP_FEAT;
    end
  end

  // Active capabilities driven straight from caps_q, with no mask applied
  assign o_active_caps = caps_q;

endmodule

// file: inc/dco_pkg.sv
// Package: register map, command codes, identify layout and structs for the overlay command block
package dco_pkg;

  // APB byte addresses
  localparam logic [7:0]  ADDR_FEATURE  = 8'h00;
  localparam logic [7:0]  ADDR_DEVICE   = 8'h04;
  localparam logic [7:0]  ADDR_COMMAND  = 8'h08;
  localparam logic [7:0]  ADDR_ERROR    = 8'h0C;
  localparam logic [7:0]  ADDR_STATUS   = 8'h10;
  localparam logic [7:0]  ADDR_DATA     = 8'h14;
  localparam logic [7:0]  ADDR_CONFIG   = 8'h18;
  localparam logic [7:0]  ADDR_CAPS     = 8'h1C;
  localparam logic [7:0]  ADDR_FLAGS    = 8'h20;

  // Command and subcommand codes
  localparam logic [7:0]  CMD_OVERLAY   = 8'hB1;
  localparam logic [7:0]  SUB_RESTORE   = 8'hC0;
  localparam logic [7:0]  SUB_FREEZE    = 8'hC1;
  localparam logic [7:0]  SUB_IDENTIFY  = 8'hC2;
  localparam logic [7:0]  SUB_SET       = 8'hC3;

  // Status, error and device bit positions
  localparam int          ST_BSY        = 7;
  localparam int          ST_DRDY       = 6;
  localparam int          ST_DF         = 5;
  localparam int          ST_DRQ        = 3;
  localparam int          ST_ERR        = 0;
  localparam int          ER_ABRT       = 2;
  localparam int          DEV_BIT       = 4;

  // Identify structure
  localparam logic [15:0] ID_REVISION   = 16'h0002;
  localparam logic [7:0]  ID_SIGNATURE  = 8'hA5;
  localparam logic [7:0]  ID_LAST_WORD  = 8'hFF;
  localparam logic [15:0] MDMA_MASK     = 16'h0007;
  localparam logic [15:0] UDMA_MASK     = 16'h007F;
  localparam logic [15:0] FEAT_MASK     = 16'h3BFF;

  // Reset values
  localparam logic [7:0]  RST_STATUS    = 8'h40;
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam logic [31:0] RST_CONFIG    = 32'h0000_0001;

  // Configuration field positions
  localparam int          CFG_SUPPORTED = 0;
  localparam int          CFG_HPA       = 1;
  localparam int          CFG_FAULT     = 2;

  // Factory capabilities, plain defaults
  localparam logic [15:0] CAP_MDMA      = 16'h0007;
  localparam logic [15:0] CAP_UDMA      = 16'h007F;
  localparam logic [15:0] CAP_FEAT      = 16'h3BFF;
  localparam logic [63:0] CAP_MAX_LBA   = 64'h0000_0000_0FFF_FFFF;

  typedef enum logic [1:0] {
    DCO_IDLE = 2'b00,
    DCO_EXEC = 2'b01,
    DCO_XFER = 2'b10
  } dco_state_t;

  typedef struct packed {
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } dco_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } dco_apb_rsp_t;

  typedef struct packed {
    logic [15:0] mdma;
    logic [15:0] udma;
    logic [15:0] feat;
  } dco_caps_t;

endpackage

// file: verif/dco_cmd_handler_assertions.sv
// Port checker for the overlay command block
module dco_cmd_handler_assertions
(
  input wire logic             i_mclk,
  input wire logic             i_reset,
  input wire logic             i_por,
  input dco_pkg::dco_apb_req_t i_apb,
  input dco_pkg::dco_apb_rsp_t o_apb,
  input dco_pkg::dco_caps_t    o_active_caps,
  input wire logic             o_frozen
);
  timeunit 1ns;
  timeprecision 1ps;
  import dco_pkg::*;
  logic       acc;
  logic       unmap;
  logic       rd_st;
  logic       rd_dat;
  logic [7:0] feat_q;
  logic [7:0] dev_q;
  logic [8:0] cnt_q;
  logic       drq_q;
  assign acc    = i_apb.psel & i_apb.penable;
  assign unmap  = (i_apb.paddr > ADDR_FLAGS) | (i_apb.paddr[1:0] != 2'b00);
  assign rd_st  = acc & !i_apb.pwrite & (i_apb.paddr == ADDR_STATUS);
  assign rd_dat = acc & !i_apb.pwrite & (i_apb.paddr == ADDR_DATA) & drq_q;
  ////////////////////////////////////////
  // Shadow of host writes, cleared like the design's task file
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
      feat_q <= 8'h00;
    else if (acc & i_apb.pwrite & (i_apb.paddr == ADDR_FEATURE))
      feat_q <= i_apb.pwdata[7:0];
  end
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
      dev_q <= 8'h00;
    else if (acc & i_apb.pwrite & (i_apb.paddr == ADDR_DEVICE))
      dev_q <= i_apb.pwdata[7:0];
  end
  // Word index restarts at each status poll, so only reads after a DRQ poll count
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      cnt_q <= 9'h000;
      drq_q <= 1'b0;
    end
    else if (rd_st)
    begin
      cnt_q <= 9'h000;
      drq_q <= o_apb.prdata[ST_DRQ];
    end
    else if (rd_dat)
      cnt_q <= cnt_q + 9'h001;
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  a_frozen_sticky: assert property (@(posedge i_mclk) disable iff (i_por) o_frozen |=> o_frozen)
    else $error("freeze flag dropped without power-on reset");
  a_freeze_cause: assert property ($rose(o_frozen) |-> feat_q == SUB_FREEZE)
    else $error("freeze flag set by another subcommand");
  a_caps_factory: assert property (o_active_caps == {CAP_MDMA, CAP_UDMA, CAP_FEAT})
    else $error("reported capabilities differ from factory set");
  a_idle_ready: assert property (rd_st && !o_apb.prdata[ST_BSY] |-> o_apb.prdata[ST_DRDY])
    else $error("idle status without DRDY");
  a_fault_err: assert property (rd_st && o_apb.prdata[ST_DF] |-> o_apb.prdata[ST_ERR])
    else $error("fault status without ERR");
  a_drq_clean: assert property (rd_st && o_apb.prdata[ST_DRQ] |-> !o_apb.prdata[ST_ERR] && !o_apb.prdata[ST_BSY])
    else $error("DRQ shown with ERR or BSY");
  a_dev_echo: assert property (acc && !i_apb.pwrite && i_apb.paddr == ADDR_DEVICE |-> o_apb.prdata[DEV_BIT] == dev_q[DEV_BIT])
    else $error("device select bit not returned");
  a_id_rev: assert property (rd_dat && cnt_q == 9'h000 |-> o_apb.prdata[15:0] == ID_REVISION)
    else $error("identify word 0 wrong");
  a_id_sig: assert property (rd_dat && cnt_q == 9'h0FF |-> o_apb.prdata[7:0] == ID_SIGNATURE)
    else $error("identify signature wrong");
  a_slverr_map: assert property (acc |-> o_apb.pslverr == unmap)
    else $error("bus error flag disagrees with register map");
endmodule
bind dco_cmd_handler dco_cmd_handler_assertions u_chk (.i_mclk(i_mclk), .i_reset(i_reset), .i_por(i_por),
  .i_apb(i_apb), .o_apb(o_apb), .o_active_caps(o_active_caps), .o_frozen(o_frozen));

// file: verif/dco_host_model.sv
// Host adapter model: APB master for the task-file registers
module dco_host_model
(
  input  wire logic             i_clk,
  output dco_pkg::dco_apb_req_t o_req,
  input  dco_pkg::dco_apb_rsp_t i_rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  import dco_pkg::*;
  initial o_req = '0;
  ////////////////////////////////////////
  // Released data lines carry the inverse, so a stale value is never mistaken
  task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge i_clk);
    o_req <= '{a, 1'b1, 1'b0, wr, d};
    @(posedge i_clk);
    o_req.penable <= 1'b1;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (i_rsp.pready !== 1'b1 && n < 32);
    q = i_rsp.prdata;
    o_req <= '{8'h00, 1'b0, 1'b0, 1'b0, ~d};
    if (i_rsp.pready !== 1'b1)
      tb_config_overlay_cmd_handler.close_out(1'b1);
  endtask
  task automatic issue(input logic [7:0] sub, input logic [7:0] cmd);
    logic [31:0] q;
    xfer(ADDR_FEATURE, 1'b1, {24'h0, sub}, q);
    xfer(ADDR_COMMAND, 1'b1, {24'h0, cmd}, q);
  endtask
endmodule

// file: verif/tb_config_overlay_cmd_handler.sv
// Self-checking bench for the overlay command block
module tb_config_overlay_cmd_handler;
  timeunit 1ns;
  timeprecision 1ps;
  import dco_pkg::*;
  logic         mclk       = 1'b0;
  logic         reset      = 1'b1;
  logic         por        = 1'b1;
  dco_apb_req_t apb_req;
  dco_apb_rsp_t apb_rsp;
  dco_caps_t    caps;
  logic         frozen;
  int           fail_count = 0;
  int           compares   = 0;
  logic [31:0]  q;
  logic [15:0]  w;
  logic [7:0]   sum;
  logic [7:0]   bad [5]    = '{8'h00, 8'hBF, 8'hC4, 8'hFF, SUB_SET};
  logic [7:0]   lock [4]   = '{SUB_FREEZE, SUB_IDENTIFY, SUB_RESTORE, SUB_SET};
  always #10 mclk = ~mclk;
  dco_cmd_handler uut (.i_mclk(mclk), .i_reset(reset), .i_por(por), .i_apb(apb_req), .o_apb(apb_rsp),
    .o_active_caps(caps), .o_frozen(frozen));
  dco_host_model host (.i_clk(mclk), .o_req(apb_req), .i_rsp(apb_rsp));
  ////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out(input logic hang);
    if (hang)
      fail_count++;
    if (fail_count == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Polls until BSY clears, then checks status and error together
  task automatic run(input logic [7:0] sub, input logic [7:0] cmd, input logic [7:0] exp);
    logic [31:0] r;
    int n;
    host.issue(sub, cmd);
    n = 0;
    do
    begin
      host.xfer(ADDR_STATUS, 1'b0, 32'h0, r);
      n++;
    end
    while (r[ST_BSY] !== 1'b0 && n < 20);
    if (r[ST_BSY] !== 1'b0)
      close_out(1'b1);
    check("status", r, {24'h0, exp});
    host.xfer(ADDR_ERROR, 1'b0, 32'h0, r);
    check("error", r, exp[ST_ERR] ? 32'h04 : 32'h00);
  endtask
  initial
  begin
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    por   <= 1'b0;
    host.xfer(ADDR_STATUS, 1'b0, 32'h0, q);
    check("reset status", q, 32'h40);
    run(SUB_IDENTIFY, CMD_OVERLAY, 8'h48);
    sum = ID_SIGNATURE;
    for (int i = 0; i < 256; i++)
    begin
      case (i)
        0: w = 16'h0002;
        1: w = 16'h0007;
        2: w = 16'h007F;
        3, 4, 5, 6: w = CAP_MAX_LBA[16 * (i - 3) +: 16];
        7: w = 16'h3BFF;
        255: w = {8'h00 - sum, ID_SIGNATURE};
        default: w = 16'h0000;
      endcase
      sum = sum + w[7:0] + w[15:8];
      host.xfer(ADDR_DATA, 1'b0, 32'h0, q);
      check("identify word", q, {16'h0, w});
    end
    host.xfer(ADDR_STATUS, 1'b0, 32'h0, q);
    check("status after data", q, 32'h40);
    foreach (bad[i]) run(bad[i], CMD_OVERLAY, 8'h41);
    run(SUB_RESTORE, 8'hB0, 8'h41);
    host.xfer(ADDR_DEVICE, 1'b1, 32'h10, q);
    host.xfer(ADDR_DEVICE, 1'b0, 32'h0, q);
    check("device", q, 32'h10);
    host.xfer(8'h24, 1'b0, 32'h0, q);
    check("unmapped", q, 32'h0);
    run(SUB_RESTORE, CMD_OVERLAY, 8'h40);
    host.xfer(ADDR_CONFIG, 1'b1, 32'h3, q);
    run(SUB_RESTORE, CMD_OVERLAY, 8'h41);
    host.xfer(ADDR_CONFIG, 1'b1, 32'h5, q);
    run(8'h00, CMD_OVERLAY, 8'h61);
    host.xfer(ADDR_CONFIG, 1'b1, 32'h0, q);
    run(SUB_IDENTIFY, CMD_OVERLAY, 8'h41);
    host.xfer(ADDR_CONFIG, 1'b1, 32'h1, q);
    run(SUB_FREEZE, CMD_OVERLAY, 8'h40);
    foreach (lock[i]) run(lock[i], CMD_OVERLAY, 8'h41);
    host.xfer(ADDR_FLAGS, 1'b0, 32'h0, q);
    check("flags", q, 32'h1);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    check("frozen after reset", {31'h0, frozen}, 32'h1);
    run(SUB_RESTORE, CMD_OVERLAY, 8'h41);
    por <= 1'b1;
    repeat (2) @(posedge mclk);
    por <= 1'b0;
    check("frozen after power-on", {31'h0, frozen}, 32'h0);
    close_out(1'b0);
  end
endmodule
